// ---- hdl/mic_pkg.sv ----
package mic_pkg;
    // =========================================================
    // time base codes
    // =========================================================
    localparam logic [1:0] TB_1S = 2'h0;
    localparam logic [1:0] TB_250MS = 2'h1;
    localparam logic [1:0] TB_15MS = 2'h2;
    localparam logic [1:0] TB_2MS = 2'h3;
    // time units in picoseconds, figures as printed
    localparam longint TB_1S_PS = 64'd1_000_000_000_000;
    localparam longint TB_250MS_PS = 64'd250_000_000_000;
    localparam longint TB_15MS_PS = 64'd15_625_000_000;
    localparam longint TB_2MS_PS = 64'd1_953_125_000;
    localparam longint CLK_PERIOD_PS = 64'd20_000;
    localparam longint LED_ON_PS = 64'd5_000_000_000;
    // cycle counts derived from the clock period
    localparam int TB_1S_CYC = int'(TB_1S_PS / CLK_PERIOD_PS);
    localparam int TB_250MS_CYC = int'(TB_250MS_PS / CLK_PERIOD_PS);
    localparam int TB_15MS_CYC = int'(TB_15MS_PS / CLK_PERIOD_PS);
    localparam int TB_2MS_CYC = int'(TB_2MS_PS / CLK_PERIOD_PS);
    localparam int LED_ON_CYC = int'(LED_ON_PS / CLK_PERIOD_PS);
    // =========================================================
    // settings
    // =========================================================
    localparam int NUM_CH = 5;
    localparam int DATA_W = 16;
    localparam int CUR_CH = 1;
    localparam logic [6:0] ADDR_DEFAULT = 7'h48;
    localparam logic [6:0] ADDR_MIN = 7'h04;
    localparam logic [6:0] ADDR_MAX = 7'h7C;
    localparam logic [2:0] AVG_M_DEFAULT = 3'h3;
    localparam logic [2:0] AVG_M_MIN = 3'h1;
    localparam logic [2:0] AVG_M_MAX = 3'h7;
    localparam logic [1:0] TB_DEFAULT = 2'h0;
    localparam logic [7:0] IVL_LO_DEFAULT = 8'h05;
    localparam logic [7:0] IVL_HI_DEFAULT = 8'h00;
    localparam logic [15:0] IVL_ONE = 16'h0001;
    // settings image stored to flash
    typedef struct packed {
        logic [6:0] addr;
        logic [2:0] avg_m;
        logic [1:0] tbase;
        logic [7:0] ivl_lo;
        logic [7:0] ivl_hi;
        logic [DATA_W-1:0] zero;
    } mic_cfg_t;
    localparam int CFG_W = $bits(mic_cfg_t);
endpackage

// ---- hdl/mic_if.sv ----
`timescale 1ns/10ps
// =========================================================
// settings image link between control and flash store
// =========================================================
interface mic_cfg_if;
    logic wr_en; // store strobe
    logic [mic_pkg::CFG_W-1:0] wr_data; // image to store
    logic [mic_pkg::CFG_W-1:0] rd_data; // stored image, registered
    logic valid; // stored image holds real settings
    modport ctrl (output wr_en, output wr_data, input rd_data, input valid);
    modport store (input wr_en, input wr_data, output rd_data, output valid);
endinterface

// ---- hdl/mic_flash.sv ----
`timescale 1ns/10ps
// =========================================================
// settings store, survives the core reset (stands for flash)
// =========================================================
module mic_flash (
    // clock
    input wire logic core_clk,
    input wire logic clk_en,
    // settings link
    mic_cfg_if.store cfg
);
    typedef struct packed {
        logic [mic_pkg::CFG_W-1:0] img;
        logic valid;
    } mic_fl_t;
    mic_fl_t st_q, st_d;

    // only a store overwrites; no reset so contents outlive power-up
    always_comb begin
        st_d = st_q;
        if (cfg.wr_en) begin
            st_d.img = cfg.wr_data;
            st_d.valid = 1'b1;
        end
    end

    // register the image
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign cfg.rd_data = st_q.img;
    assign cfg.valid = st_q.valid === 1'b1;
endmodule // mic_flash

// ---- hdl/mic_ctrl.sv ----
`timescale 1ns/10ps
// Overview of operation
// RQ1 - two-bit code selects time unit
// RQ2 - interval equals unit times sixteen-bit factor
// RQ3 - factor is high byte times 256 plus low
// RQ4 - host keeps interval at least 7.8125 ms
// RQ5 - led lit about 5 ms per measurement
// RQ6 - averaging runs at measurement rate only
// RQ7 - written settings take effect at once
// RQ8 - store command saves settings, reload at power-up
// RQ9 - zero command captures current average as offset
// RQ10 - host zeroes only without current, then stores
// RQ11 - restore defaults marks, applies at power-up
// RQ12 - stats reset sets avg min max present
// RQ13 - host reads data in two block reads
// RQ14 - host polls once per log interval
// RQ15 - address configurable 0x04..0x7C, default 0x48
// RQ16 - moving average weight 1/2^M, M 1..7
// RQ17 - factor zero behaves as factor one
// RQ18 - interval counter counts ticks, reloads at factor
module mic_ctrl #(
    parameter int NUM_CH = mic_pkg::NUM_CH,
    parameter int DATA_W = mic_pkg::DATA_W,
    parameter int TB_1S_CYC = mic_pkg::TB_1S_CYC,
    parameter int TB_250MS_CYC = mic_pkg::TB_250MS_CYC,
    parameter int TB_15MS_CYC = mic_pkg::TB_15MS_CYC,
    parameter int TB_2MS_CYC = mic_pkg::TB_2MS_CYC,
    parameter int LED_ON_CYC = mic_pkg::LED_ON_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // setting writes, one strobe per field
    input wire logic addr_wr,
    input wire logic [6:0] addr_wdata,
    input wire logic avg_m_wr,
    input wire logic [2:0] avg_m_wdata,
    input wire logic tbase_wr,
    input wire logic [1:0] tbase_wdata,
    input wire logic ivl_lo_wr,
    input wire logic [7:0] ivl_lo_wdata,
    input wire logic ivl_hi_wr,
    input wire logic [7:0] ivl_hi_wdata,
    // commands, one-cycle pulses
    input wire logic cmd_store,
    input wire logic cmd_zero,
    input wire logic cmd_defaults,
    input wire logic cmd_stats_reset,
    // raw samples from the front end
    input wire logic [NUM_CH*DATA_W-1:0] sample,
    // settings in force, and the defaults mark
    output logic [6:0] i2c_addr,
    output logic [2:0] avg_m,
    output logic [1:0] tbase,
    output logic [15:0] ivl_factor,
    output logic [DATA_W-1:0] cur_zero,
    output logic defaults_pending,
    // measurement results
    output logic meas_strobe,
    output logic led,
    output logic [NUM_CH*DATA_W-1:0] avg_out,
    output logic [NUM_CH*DATA_W-1:0] min_out,
    output logic [NUM_CH*DATA_W-1:0] max_out
);
    // =========================================================
    // state
    // =========================================================
    typedef enum logic [1:0] {MIC_BOOT, MIC_RUN} mic_phase_t;
    typedef struct packed {
        mic_phase_t phase;
        mic_pkg::mic_cfg_t cfg; // settings in force
        logic dflt_q; // defaults marked for next power-up
        logic [31:0] tick_cnt; // time base prescaler
        logic [15:0] ivl_cnt; // ticks in current interval
        logic meas; // measurement pulse
        logic [31:0] led_cnt; // led on-time remaining
        logic [NUM_CH-1:0][DATA_W-1:0] avg;
        logic [NUM_CH-1:0][DATA_W-1:0] mn;
        logic [NUM_CH-1:0][DATA_W-1:0] mx;
    } mic_st_t;
    mic_st_t st_q, st_d;

    mic_cfg_if cfg_link ();
    logic [15:0] factor; // effective factor
    logic [31:0] unit_cyc; // cycles per time unit
    logic [NUM_CH-1:0][DATA_W-1:0] smp;
    logic [NUM_CH-1:0][DATA_W-1:0] avg_nx;
    mic_pkg::mic_cfg_t dflt_cfg;

    // =========================================================
    // settings store
    // =========================================================
    mic_flash u_flash (
        .core_clk(core_clk),
        .clk_en(clk_en),
        .cfg(cfg_link.store)
    );
    // a defaults command writes the factory image into the store, so the defaults
    // survive the power-up reset that clears the mark; the running settings stay untouched
    assign cfg_link.wr_en = (cmd_store || cmd_defaults) && st_q.phase == MIC_RUN; // RQ8 RQ11
    assign cfg_link.wr_data = cmd_defaults ? dflt_cfg : st_q.cfg; // RQ11

    always_comb begin
        dflt_cfg.addr = mic_pkg::ADDR_DEFAULT;
        dflt_cfg.avg_m = mic_pkg::AVG_M_DEFAULT;
        dflt_cfg.tbase = mic_pkg::TB_DEFAULT;
        dflt_cfg.ivl_lo = mic_pkg::IVL_LO_DEFAULT;
        dflt_cfg.ivl_hi = mic_pkg::IVL_HI_DEFAULT;
        dflt_cfg.zero = '0;
    end

    // =========================================================
    // derived values
    // =========================================================
    // unit selection from the time base code
    always_comb begin
        unique case (st_q.cfg.tbase)
            mic_pkg::TB_1S: unit_cyc = 32'(TB_1S_CYC); // RQ1
            mic_pkg::TB_250MS: unit_cyc = 32'(TB_250MS_CYC); // RQ1
            mic_pkg::TB_15MS: unit_cyc = 32'(TB_15MS_CYC); // RQ1
            mic_pkg::TB_2MS: unit_cyc = 32'(TB_2MS_CYC); // RQ1
        endcase
    end

    // factor from the two bytes; zero acts as one
    always_comb begin
        factor = {st_q.cfg.ivl_hi, st_q.cfg.ivl_lo}; // RQ3
        if (factor == '0) begin
            factor = mic_mic_one(); // RQ17
        end
    end

    function automatic logic [15:0] mic_mic_one();
        return mic_pkg::IVL_ONE;
    endfunction

    // moving average per channel: avg + (sample - avg) / 2^M
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic signed [DATA_W+1:0] diff;
        assign smp[c] = sample[c*DATA_W +: DATA_W];
        assign diff = $signed({2'b00, smp[c]}) - $signed({2'b00, st_q.avg[c]});
        assign avg_nx[c] = DATA_W'($signed({2'b00, st_q.avg[c]}) + (diff >>> st_q.cfg.avg_m)); // RQ16
        assign avg_out[c*DATA_W +: DATA_W] = st_q.avg[c];
        assign min_out[c*DATA_W +: DATA_W] = st_q.mn[c];
        assign max_out[c*DATA_W +: DATA_W] = st_q.mx[c];
    end

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        st_d = st_q;
        st_d.meas = 1'b0;
        unique case (st_q.phase)
            // power-up: load stored image if it is valid and no defaults are marked, else defaults
            MIC_BOOT: begin
                if (cfg_link.valid && !st_q.dflt_q) begin
                    st_d.cfg = mic_mic_cfg(cfg_link.rd_data); // RQ8
                end else begin
                    st_d.cfg = dflt_cfg; // RQ11
                end
                st_d.dflt_q = 1'b0;
                st_d.phase = MIC_RUN;
            end
            MIC_RUN: begin
                // writes take effect on the next cycle
                if (addr_wr && addr_wdata >= mic_pkg::ADDR_MIN && addr_wdata <= mic_pkg::ADDR_MAX) begin
                    st_d.cfg.addr = addr_wdata; // RQ15 RQ7
                end
                if (avg_m_wr && avg_m_wdata >= mic_pkg::AVG_M_MIN) begin
                    st_d.cfg.avg_m = avg_m_wdata; // RQ16 RQ7
                end
                if (tbase_wr) begin
                    st_d.cfg.tbase = tbase_wdata; // RQ7
                end
                if (ivl_lo_wr) begin
                    st_d.cfg.ivl_lo = ivl_lo_wdata; // RQ3 RQ7
                end
                if (ivl_hi_wr) begin
                    st_d.cfg.ivl_hi = ivl_hi_wdata; // RQ3 RQ7
                end
                // defaults only marked; running settings kept
                if (cmd_defaults) begin
                    st_d.dflt_q = 1'b1; // RQ11
                end
                // the host guarantees no current flows here
                if (cmd_zero) begin
                    st_d.cfg.zero = st_q.avg[mic_pkg::CUR_CH]; // RQ9 RQ10
                end
                // time base prescaler, then interval counter
                if (st_q.tick_cnt >= unit_cyc - 32'd1) begin
                    st_d.tick_cnt = '0;
                    if (st_q.ivl_cnt >= factor - 16'd1) begin
                        st_d.ivl_cnt = '0; // RQ18
                        st_d.meas = 1'b1; // RQ2
                    end else begin
                        st_d.ivl_cnt = st_q.ivl_cnt + 16'd1; // RQ18
                    end
                end else begin
                    st_d.tick_cnt = st_q.tick_cnt + 32'd1;
                end
                // averaging and statistics only at measurement time
                if (st_q.meas) begin
                    st_d.led_cnt = 32'(LED_ON_CYC); // RQ5
                    for (int c = 0; c < NUM_CH; c++) begin
                        st_d.avg[c] = avg_nx[c]; // RQ6
                        if (smp[c] < st_q.mn[c]) begin
                            st_d.mn[c] = smp[c];
                        end
                        if (smp[c] > st_q.mx[c]) begin
                            st_d.mx[c] = smp[c];
                        end
                    end
                end else if (st_q.led_cnt != '0) begin
                    st_d.led_cnt = st_q.led_cnt - 32'd1; // RQ5
                end
                // stats reset wins over a same-cycle update
                if (cmd_stats_reset) begin
                    for (int c = 0; c < NUM_CH; c++) begin
                        st_d.avg[c] = smp[c]; // RQ12
                        st_d.mn[c] = smp[c]; // RQ12
                        st_d.mx[c] = smp[c]; // RQ12
                    end
                end
            end
            default: st_d.phase = MIC_BOOT;
        endcase
    end

    function automatic mic_pkg::mic_cfg_t mic_mic_cfg(input logic [mic_pkg::CFG_W-1:0] v);
        return mic_pkg::mic_cfg_t'(v);
    endfunction

    // register state; reset returns to power-up load
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    assign i2c_addr = st_q.cfg.addr;
    assign avg_m = st_q.cfg.avg_m;
    assign tbase = st_q.cfg.tbase;
    assign ivl_factor = factor;
    assign cur_zero = st_q.cfg.zero;
    assign defaults_pending = st_q.dflt_q;
    assign meas_strobe = st_q.meas;
    assign led = st_q.led_cnt != '0; // RQ5
endmodule // mic_ctrl

// ---- tb/mic_ctrl_checker.sv ----
`timescale 1ns/10ps
// ==========================================
// checks on settings, interval and statistics
// ==========================================
module mic_ctrl_checker #(
    parameter int DATA_W = 16,
    parameter int TB_1S_CYC = 1024,
    parameter int TB_250MS_CYC = 256,
    parameter int TB_15MS_CYC = 16,
    parameter int TB_2MS_CYC = 2
) (
    // clock, reset and setting writes
    input wire logic core_clk, resetn, clk_en, addr_wr, avg_m_wr, tbase_wr, ivl_lo_wr, ivl_hi_wr,
    input wire logic [6:0] addr_wdata,
    input wire logic [2:0] avg_m_wdata,
    input wire logic [1:0] tbase_wdata,
    input wire logic [7:0] ivl_lo_wdata, ivl_hi_wdata,
    // commands and results
    input wire logic cmd_zero, cmd_stats_reset, meas_strobe, led,
    input wire logic [6:0] i2c_addr,
    input wire logic [2:0] avg_m,
    input wire logic [1:0] tbase,
    input wire logic [15:0] ivl_factor,
    input wire logic [DATA_W-1:0] cur_zero,
    input wire logic [mic_pkg::NUM_CH*DATA_W-1:0] sample, avg_out, min_out, max_out
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // cycles since the last strobe; a period is judged only if no interval setting moved meanwhile
    int gap_q;
    logic ok_q;
    int unit;
    assign unit = tbase == 2'h0 ? TB_1S_CYC : tbase == 2'h1 ? TB_250MS_CYC : tbase == 2'h2 ? TB_15MS_CYC : TB_2MS_CYC;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gap_q <= 0;
            ok_q <= 1'b0;
        end else if (clk_en) begin
            gap_q <= meas_strobe ? 1 : gap_q + 1;
            ok_q <= (meas_strobe | ok_q) & ~(tbase_wr | ivl_lo_wr | ivl_hi_wr);
        end
    end
    // ==========================================
    // assertions
    // ==========================================
    a_period_exact: assert property (meas_strobe && ok_q |-> gap_q == unit * int'(ivl_factor))
        else $error("measurement period wrong");
    a_factor_never_zero: assert property (ivl_factor != 16'h0000)
        else $error("interval factor zero");
    a_lo_byte_taken: assert property (clk_en && ivl_lo_wr |=>
        ivl_factor[7:0] == $past(ivl_lo_wdata) || ivl_factor == 16'h0001) else $error("low byte not taken");
    a_hi_byte_taken: assert property (clk_en && ivl_hi_wr |=> ivl_factor[15:8] == $past(ivl_hi_wdata))
        else $error("high byte not taken");
    a_tbase_taken: assert property (clk_en && tbase_wr |=> tbase == $past(tbase_wdata))
        else $error("time base not taken");
    a_addr_range: assert property (clk_en && addr_wr && (addr_wdata < 7'h04 || addr_wdata > 7'h7C) |=>
        $stable(i2c_addr)) else $error("bad address accepted");
    a_avg_weight_range: assert property (clk_en && avg_m_wr |=> avg_m == $past(avg_m_wdata) ||
        $past(avg_m_wdata) == 3'h0 && $stable(avg_m)) else $error("averaging weight wrong");
    a_stats_present: assert property (clk_en && cmd_stats_reset |=> avg_out == $past(sample) &&
        min_out == $past(sample) && max_out == $past(sample)) else $error("statistics not reset");
    a_zero_taken: assert property (clk_en && cmd_zero |=> cur_zero == $past(avg_out[DATA_W +: DATA_W]))
        else $error("zero reference wrong");
    // led on time of three cycles stands exactly three cycles
    a_led_width: assert property ($rose(led) |-> led [*3] ##1 !led)
        else $error("led pulse width wrong");
    c_period: cover property (meas_strobe && ok_q);
    c_zero: cover property (clk_en && cmd_zero);
    c_stats: cover property (clk_en && cmd_stats_reset);
endmodule // mic_ctrl_checker

bind mic_ctrl mic_ctrl_checker #(.DATA_W(DATA_W), .TB_1S_CYC(TB_1S_CYC), .TB_250MS_CYC(TB_250MS_CYC),
    .TB_15MS_CYC(TB_15MS_CYC), .TB_2MS_CYC(TB_2MS_CYC)) mic_ctrl_checker_i (.core_clk, .resetn, .clk_en,
    .addr_wr, .avg_m_wr, .tbase_wr, .ivl_lo_wr, .ivl_hi_wr, .addr_wdata, .avg_m_wdata, .tbase_wdata,
    .ivl_lo_wdata, .ivl_hi_wdata, .cmd_zero, .cmd_stats_reset, .meas_strobe, .led, .i2c_addr, .avg_m,
    .tbase, .ivl_factor, .cur_zero, .sample, .avg_out, .min_out, .max_out);

// ---- tb/mic_host.sv ----
`timescale 1ns/10ps
// ==========================================
// host model: one-cycle setting writes and commands
// ==========================================
module mic_host (
    // clock
    input wire logic core_clk,
    // strobes: addr, avg_m, tbase, ivl_lo, ivl_hi
    output logic [4:0] wr,
    output logic [7:0] wdata,
    // commands: store, zero, defaults, stats reset
    output logic [3:0] cmd
);
    // everything idle before the first falling edge
    initial begin
        wr = 5'h00;
        wdata = 8'h00;
        cmd = 4'h0;
    end
    // data is inverted once released so a stale byte never looks valid
    task automatic write(input int f, input logic [7:0] d);
        @(negedge core_clk);
        wr[f] = 1'b1;
        wdata = d;
        @(negedge core_clk);
        wr[f] = 1'b0;
        wdata = ~d;
    endtask
    // zero is sent only while the current channel reads its no-current offset
    task automatic command(input int c);
        @(negedge core_clk);
        cmd[c] = 1'b1;
        @(negedge core_clk);
        cmd[c] = 1'b0;
    endtask
endmodule // mic_host

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
// ==========================================
// bench for the measurement interval control
// ==========================================
module testbench;
    // clock, reset and samples; ch1 holds the no-current offset
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1; // low freezes the block
    logic [79:0] sample = 80'h0400_0300_0200_0012_0100;
    // host side and block outputs
    logic [4:0] wr;
    logic [7:0] wdata;
    logic [3:0] cmd;
    logic [6:0] i2c_addr;
    logic [2:0] avg_m;
    logic [1:0] tbase;
    logic [15:0] ivl_factor, cur_zero;
    logic defaults_pending, meas_strobe, led;
    logic [79:0] avg_out, min_out, max_out;
    int fails = 0;
    int n_tests = 0;
    int n;
    // scaled units per code, keeping the 512:128:8:1 ratios
    int unit[4] = '{1024, 256, 16, 2};
    // scaled led on-time, and the per-channel sample step (current channel held)
    localparam int LED_CYC = 3;
    localparam logic [79:0] STEP = 80'h0100_0100_0100_0000_0100;
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    mic_host mic_host_i (.core_clk, .wr, .wdata, .cmd);
    mic_ctrl #(.TB_1S_CYC(1024), .TB_250MS_CYC(256), .TB_15MS_CYC(16), .TB_2MS_CYC(2), .LED_ON_CYC(LED_CYC))
    mic_ctrl_i (
        .core_clk, .resetn, .clk_en, .addr_wr(wr[0]), .addr_wdata(wdata[6:0]), .avg_m_wr(wr[1]),
        .avg_m_wdata(wdata[2:0]), .tbase_wr(wr[2]), .tbase_wdata(wdata[1:0]), .ivl_lo_wr(wr[3]),
        .ivl_lo_wdata(wdata), .ivl_hi_wr(wr[4]), .ivl_hi_wdata(wdata), .cmd_store(cmd[0]), .cmd_zero(cmd[1]),
        .cmd_defaults(cmd[2]), .cmd_stats_reset(cmd[3]), .sample, .i2c_addr, .avg_m, .tbase, .ivl_factor,
        .cur_zero, .defaults_pending, .meas_strobe, .led, .avg_out, .min_out, .max_out);
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // two reset cycles, then skip the boot load cycle before any request
    task automatic do_reset;
        @(negedge core_clk);
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask
    // n counts cycles up to the next measurement strobe, bounded
    task automatic wait_meas;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (meas_strobe !== 1'b1 && n < 12000);
    endtask
    task automatic t_defaults;
        chk({i2c_addr, avg_m, tbase}, {mic_pkg::ADDR_DEFAULT, mic_pkg::AVG_M_DEFAULT, mic_pkg::TB_DEFAULT});
        chk({defaults_pending, cur_zero, ivl_factor}, 33'h0_0000_0005);
    endtask
    // a write while the enable is low must leave the settings as they were
    task automatic t_freeze;
        @(negedge core_clk);
        clk_en = 1'b0;
        mic_host_i.write(2, 8'h02);
        chk(tbase, mic_pkg::TB_DEFAULT);
        clk_en = 1'b1;
    endtask
    // a zero factor, every code, then a factor with the high byte set
    task automatic t_interval;
        mic_host_i.write(3, 8'h00);
        chk(ivl_factor, 16'h0001);
        for (int c = 0; c < 4; c++) begin
            mic_host_i.write(2, 8'(c));
            mic_host_i.write(3, 8'h04);
            wait_meas;
            wait_meas;
            chk(n, unit[c] * 4);
        end
        mic_host_i.write(4, 8'h01);
        wait_meas;
        wait_meas;
        chk(n, 16'h0104 * 2);
        // step past the launching edge before the led level is looked at
        if (led !== 1'b1) @(posedge core_clk);
        #1;
        n = 0;
        while (led === 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(n, LED_CYC);
    endtask
    task automatic t_settings;
        mic_host_i.write(0, 8'h03);
        mic_host_i.write(0, 8'h7D);
        mic_host_i.write(1, 8'h00);
        chk({i2c_addr, avg_m}, {mic_pkg::ADDR_DEFAULT, mic_pkg::AVG_M_DEFAULT});
        mic_host_i.write(0, 8'h04);
        chk(i2c_addr, mic_pkg::ADDR_MIN);
        mic_host_i.write(0, 8'h7C);
        mic_host_i.write(1, 8'h07);
        chk({i2c_addr, avg_m}, 10'h3E7);
    endtask
    task automatic t_stats_zero;
        mic_host_i.command(3);
        chk(avg_out, sample);
        chk(min_out, sample);
        chk(max_out, sample);
        mic_host_i.command(1);
        chk(cur_zero, 16'h0012);
        sample = sample + STEP;
        wait_meas;
        repeat (2) @(posedge core_clk);
        #1;
        chk(max_out, sample);
        chk(min_out, sample - STEP);
        // one measurement at weight 1/2^7 moves each average by a 128th of the step
        chk(avg_out, sample - STEP + (STEP >> mic_pkg::AVG_M_MAX));
    endtask
    task automatic t_store;
        mic_host_i.write(0, 8'h30);
        mic_host_i.command(0);
        do_reset;
        chk({i2c_addr, cur_zero}, 23'h30_0012);
        // defaults are only marked now, and replace the settings at the next power-up
        mic_host_i.command(2);
        chk({defaults_pending, i2c_addr}, 8'hB0);
        do_reset;
        chk({defaults_pending, i2c_addr, cur_zero}, {1'b0, mic_pkg::ADDR_DEFAULT, 16'h0000});
        chk({avg_m, tbase}, {mic_pkg::AVG_M_DEFAULT, mic_pkg::TB_DEFAULT});
    endtask
    initial begin
        do_reset;
        t_defaults;
        t_freeze;
        t_interval;
        t_settings;
        t_stats_zero;
        t_store;
        conclude;
    end
    // the tests need about 12k cycles; this allows some 50k
    initial begin
        #1_000_000;
        fails++;
        conclude;
    end
endmodule // testbench
